// ### shared/rxs_pkg.sv
package rxs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [7:0] RXS_IDX_STATUS   = 8'h08;
  localparam logic [7:0] RXS_IDX_COUNT    = 8'h09;
  localparam logic [7:0] RXS_IDX_IRQ_STAT = 8'h0C;
  localparam logic [7:0] RXS_IDX_IRQ_MASK = 8'h0D;
  localparam int         RXS_IDX_LSB      = 2;
  localparam int         RXS_IDX_W        = 8;

  ////////////////////////////////////////////////////////////////////////////
  // status register fields
  localparam int RXS_ST_ACK      = 7;
  localparam int RXS_ST_TYPE_ERR = 6;
  localparam int RXS_ST_UNEXPECTED_END_FLAG  = 5;
  localparam int RXS_ST_ZERO     = 4;
  localparam int RXS_ST_BAD_CRC  = 3;
  localparam int RXS_ST_CODE     = 2;
  localparam int RXS_ST_MODE_LSB = 0;

  // data mode encodings
  localparam logic [1:0] RXS_MODE_GFSK  = 2'b00;
  localparam logic [1:0] RXS_MODE_8CHIP = 2'b01;
  localparam logic [1:0] RXS_MODE_DDR   = 2'b10;
  localparam logic [1:0] RXS_MODE_BAD   = 2'b11;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask fields
  localparam int RXS_IRQ_W        = 4;
  localparam int RXS_IRQ_DONE     = 0;
  localparam int RXS_IRQ_BAD_CRC  = 1;
  localparam int RXS_IRQ_UNEXPECTED_END_FLAG  = 2;
  localparam int RXS_IRQ_TYPE_ERR = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]           RXS_STATUS_RST = 8'h00;
  localparam logic [7:0]           RXS_COUNT_RST  = 8'h00;
  localparam logic [RXS_IRQ_W-1:0] RXS_IRQ_RST    = 4'h0;
  localparam logic [31:0]          RXS_RDATA_RST  = 32'h0000_0000;

endpackage

// ### verilog/rxs_ahb_slave.sv
module rxs_ahb_slave
  import rxs_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic                 hready,
  output logic                      rd_take,
  output logic [RXS_IDX_W-1:0]      addr_idx,
  output logic                      wr_en,
  output logic [RXS_IDX_W-1:0]      wr_idx
);

  logic                 wr_pend_reg;
  logic [RXS_IDX_W-1:0] wr_idx_reg;
  wire                  take;

  // zero wait states, so every address phase seen with hready is accepted
  assign take     = hsel & htrans[1] & hready;
  assign rd_take  = take & ~hwrite;
  assign addr_idx = haddr[RXS_IDX_LSB +: RXS_IDX_W];
  assign wr_en    = wr_pend_reg;
  assign wr_idx   = wr_idx_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= '0;
    end else begin
      wr_pend_reg <= take & hwrite;
      if (take) begin
        wr_idx_reg <= addr_idx;
      end
    end
  end

endmodule

// ### verilog/rxs_byte_counter.sv
module rxs_byte_counter
  import rxs_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clear,
  input  wire logic             incr,
  output logic [WIDTH-1:0]      count
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  wire              at_top;

  // saturate so an overlong packet cannot wrap back to a matching value
  assign at_top     = &count_reg;
  assign count_next = clear ? '0 :
                      (incr & ~at_top) ? count_reg + 1'b1 : count_reg;
  assign count      = count_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= RXS_COUNT_RST[WIDTH-1:0];
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// ### verilog/rxs_top.sv
// How it works
// - type error set when received packet type differs from expected, else cleared
// - unexpected-end set when end arrives before length and checksum complete, unless end comes in the checksum cycle
// - unexpected-end cleared only by start of the following packet
// - invalid length field forces length zero and sets unexpected-end
// - code bit of last good packet: one is 64 chips, zero 32
// - two-bit data mode of last good packet: 00, 01, 10; 11 invalid
// - data mode is not updated and is meaningless after unframed packets
//
// Design decision made here: register access over AHB-Lite.
module rxs_top
  import rxs_pkg::*;
#(
  parameter int COUNT_W = 8
)
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               start_of_packet,
  input  wire logic               end_of_packet,
  input  wire logic               length_load,
  input  wire logic [7:0]         length_field,
  input  wire logic               length_invalid,
  input  wire logic               rx_go_restart,
  input  wire logic               payload_byte,
  input  wire logic               crc_done,
  input  wire logic               crc_bad,
  input  wire logic               crc_zero_seed,
  input  wire logic               rx_is_ack,
  input  wire logic               expect_ack,
  input  wire logic               rx_code_64,
  input  wire logic [1:0]         rx_data_mode,
  input  wire logic               rx_framed,
  output logic [7:0]              rx_length,
  output logic                    irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  logic                 rd_take;
  logic [RXS_IDX_W-1:0] addr_idx;
  logic                 wr_en;
  logic [RXS_IDX_W-1:0] wr_idx;

  rxs_ahb_slave u_slave (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .hsel     (hsel),
    .haddr    (haddr),
    .htrans   (htrans),
    .hwrite   (hwrite),
    .hready   (hready),
    .rd_take  (rd_take),
    .addr_idx (addr_idx),
    .wr_en    (wr_en),
    .wr_idx   (wr_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // payload byte counter
  logic [COUNT_W-1:0] byte_count;
  wire                count_clear;

  assign count_clear = length_load | rx_go_restart;

  rxs_byte_counter #(
    .WIDTH (COUNT_W)
  ) u_count (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clear   (count_clear),
    .incr    (payload_byte),
    .count   (byte_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // packet progress tracking
  logic       len_seen_reg;
  logic       crc_seen_reg;
  logic [7:0] rx_length_reg;
  wire        body_complete;
  wire        early_end;

  // both the length and the checksum must have landed before end is legal, unless end comes in the checksum cycle
  assign body_complete = len_seen_reg & crc_seen_reg &
                         (byte_count == rx_length_reg[COUNT_W-1:0]);
  assign early_end     = end_of_packet & ~(body_complete | crc_done);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len_seen_reg  <= 1'b0;
      crc_seen_reg  <= 1'b0;
      rx_length_reg <= 8'h00;
    end else begin
      if (start_of_packet) begin
        len_seen_reg <= 1'b0;
        crc_seen_reg <= 1'b0;
      end
      if (length_load) begin
        len_seen_reg  <= 1'b1;
        rx_length_reg <= length_invalid ? 8'h00 : length_field;
      end
      if (crc_done) begin
        crc_seen_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive status
  logic       ack_reg;
  logic       type_err_reg;
  logic       unexpected_end_flag_reg;
  logic       zero_reg;
  logic       bad_crc_reg;
  logic       code_reg;
  logic [1:0] mode_reg;
  wire        unexpected_end_flag_set;
  wire        type_mismatch;
  wire        good_packet;
  wire [7:0]  status_word;

  assign unexpected_end_flag_set   = early_end | (length_load & length_invalid);
  assign type_mismatch = rx_is_ack ^ expect_ack;
  assign good_packet   = crc_done & ~crc_bad;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_reg      <= RXS_STATUS_RST[RXS_ST_ACK];
      type_err_reg <= RXS_STATUS_RST[RXS_ST_TYPE_ERR];
      unexpected_end_flag_reg  <= RXS_STATUS_RST[RXS_ST_UNEXPECTED_END_FLAG];
      zero_reg     <= RXS_STATUS_RST[RXS_ST_ZERO];
      bad_crc_reg  <= RXS_STATUS_RST[RXS_ST_BAD_CRC];
      code_reg     <= RXS_STATUS_RST[RXS_ST_CODE];
      mode_reg     <= RXS_STATUS_RST[RXS_ST_MODE_LSB +: 2];
    end else begin
      // a new error in the start cycle still wins over the clear
      if (unexpected_end_flag_set) begin
        unexpected_end_flag_reg <= 1'b1;
      end else if (start_of_packet) begin
        unexpected_end_flag_reg <= 1'b0;
      end
      if (crc_done) begin
        ack_reg      <= rx_is_ack;
        type_err_reg <= type_mismatch;
        bad_crc_reg  <= crc_bad;
        zero_reg     <= crc_zero_seed;
      end
      if (good_packet) begin
        code_reg <= rx_code_64;
      end
      // unframed packets carry no mode, so the old value is left alone
      if (good_packet & rx_framed) begin
        mode_reg <= rx_data_mode;
      end
    end
  end

  assign status_word = {ack_reg, type_err_reg, unexpected_end_flag_reg, zero_reg,
                        bad_crc_reg, code_reg, mode_reg};

  ////////////////////////////////////////////////////////////////////////////
  // interrupts
  logic [RXS_IRQ_W-1:0] irq_stat_reg;
  logic [RXS_IRQ_W-1:0] irq_mask_reg;
  logic [RXS_IRQ_W-1:0] irq_events;
  logic [RXS_IRQ_W-1:0] irq_clear;
  logic [RXS_IRQ_W-1:0] irq_stat_next;
  logic                 irq_reg;
  wire                  wr_irq_stat;
  wire                  wr_irq_mask;

  assign irq_events[RXS_IRQ_DONE]     = crc_done;
  assign irq_events[RXS_IRQ_BAD_CRC]  = crc_done & crc_bad;
  assign irq_events[RXS_IRQ_UNEXPECTED_END_FLAG]  = unexpected_end_flag_set;
  assign irq_events[RXS_IRQ_TYPE_ERR] = crc_done & type_mismatch;

  assign wr_irq_stat   = wr_en & (wr_idx == RXS_IDX_IRQ_STAT);
  assign wr_irq_mask   = wr_en & (wr_idx == RXS_IDX_IRQ_MASK);
  assign irq_clear     = wr_irq_stat ? hwdata[RXS_IRQ_W-1:0] : '0;
  // set wins over a write-one clear in the same cycle
  assign irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_events;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= RXS_IRQ_RST;
      irq_mask_reg <= RXS_IRQ_RST;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_irq_mask) begin
        irq_mask_reg <= hwdata[RXS_IRQ_W-1:0];
      end
      irq_reg <= |(irq_stat_next & (wr_irq_mask ? hwdata[RXS_IRQ_W-1:0] : irq_mask_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured at the address phase so the data phase has no wait
  logic [31:0] hrdata_reg;
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_idx)
      RXS_IDX_STATUS:   rd_mux[7:0] = status_word;
      RXS_IDX_COUNT:    rd_mux[COUNT_W-1:0] = byte_count;
      RXS_IDX_IRQ_STAT: rd_mux[RXS_IRQ_W-1:0] = irq_stat_reg;
      RXS_IDX_IRQ_MASK: rd_mux[RXS_IRQ_W-1:0] = irq_mask_reg;
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= RXS_RDATA_RST;
    end else if (rd_take) begin
      hrdata_reg <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  logic hreadyout_reg;
  logic hresp_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;
  assign rx_length = rx_length_reg;
  assign irq       = irq_reg;

endmodule

// ### bench/rxs_top_sva.sv
module rxs_top_sva
  import rxs_pkg::*;
#(
  parameter int COUNT_W = 8
)
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        length_load,
  input wire logic        length_invalid,
  input wire logic        crc_done,
  input wire logic        crc_bad,
  input wire logic        crc_zero_seed,
  input wire logic        rx_is_ack,
  input wire logic        expect_ack,
  input wire logic        rx_code_64,
  input wire logic [1:0]  rx_data_mode,
  input wire logic        rx_framed,
  input wire logic [7:0]  rx_length
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  wire logic [7:0] idx = haddr[RXS_IDX_LSB +: RXS_IDX_W];
  wire logic rd = hsel && htrans[1] && hready && !hwrite;
  wire logic rd_st = rd && idx == RXS_IDX_STATUS;
  wire logic rd_gap = rd && !(idx inside {RXS_IDX_STATUS, RXS_IDX_COUNT,
                                         RXS_IDX_IRQ_STAT, RXS_IDX_IRQ_MASK});

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // status read one cycle after the checksum result, data two cycles on
  sequence crc_read;
    crc_done ##1 rd_st;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  a_len_forced: assert property (length_load && length_invalid |=> rx_length == 8'h00)
    else $error("invalid length not forced to zero");
  a_type_error: assert property (crc_read |=> hrdata[RXS_ST_TYPE_ERR] ==
      ($past(rx_is_ack, 2) != $past(expect_ack, 2)))
    else $error("type error bit wrong");
  a_ack_bit: assert property (crc_read |=> hrdata[RXS_ST_ACK] == $past(rx_is_ack, 2))
    else $error("packet type bit wrong");
  a_crc_bits: assert property (crc_read |=> hrdata[4:3] ==
      {$past(crc_zero_seed, 2), $past(crc_bad, 2)})
    else $error("checksum bits wrong");
  a_good_mode: assert property (crc_done && !crc_bad && rx_framed ##1 rd_st |=>
      hrdata[2:0] == {$past(rx_code_64, 2), $past(rx_data_mode, 2)})
    else $error("code or mode of good packet wrong");
  a_unmapped_zero: assert property (rd_gap |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  c_good_read: cover property (crc_done && !crc_bad ##1 rd_st);
  c_bad_crc: cover property (crc_done && crc_bad);
  c_bad_len: cover property (length_load && length_invalid);
endmodule

bind rxs_top rxs_top_sva #(.COUNT_W(COUNT_W)) i_rxs_top_sva (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .length_load, .length_invalid, .crc_done, .crc_bad, .crc_zero_seed,
  .rx_is_ack, .expect_ack, .rx_code_64, .rx_data_mode, .rx_framed, .rx_length
);

// ### bench/rxs_tx_model.sv
module rxs_tx_model (
  input wire logic   hclk,
  output logic       start_of_packet,
  output logic       end_of_packet,
  output logic       length_load,
  output logic [7:0] length_field,
  output logic       length_invalid,
  output logic       payload_byte,
  output logic       crc_done,
  output logic       crc_bad,
  output logic       crc_zero_seed,
  output logic       rx_is_ack,
  output logic       expect_ack,
  output logic       rx_code_64,
  output logic [1:0] rx_data_mode,
  output logic       rx_framed
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  // qual packs ack, expected ack, framed, zero seed, bad, code, mode
  logic [7:0] qual;
  assign {rx_is_ack, expect_ack, rx_framed, crc_zero_seed, crc_bad, rx_code_64,
          rx_data_mode} = qual;

  initial begin
    {start_of_packet, end_of_packet, length_load, length_invalid} = 4'h0;
    {payload_byte, crc_done} = 2'b00;
    length_field = 8'h00;
    qual = 8'h00;
  end

  // cut drops payload and checksum; qualifiers flip outside their pulse
  // so a receiver that samples late sees garbage, not a stale match
  task automatic send(input logic [7:0] len, input logic [7:0] q, input bit cut, input bit bl);
    @(posedge hclk);
    start_of_packet <= 1'b1;
    @(posedge hclk);
    start_of_packet <= 1'b0;
    length_load <= 1'b1;
    length_field <= len;
    length_invalid <= bl;
    @(posedge hclk);
    length_load <= 1'b0;
    length_field <= ~len;
    length_invalid <= ~bl;
    if (!cut) begin
      repeat (len) begin
        payload_byte <= 1'b1;
        @(posedge hclk);
      end
      payload_byte <= 1'b0;
      qual <= q;
      crc_done <= 1'b1;
      @(posedge hclk);
      crc_done <= 1'b0;
      qual <= ~q;
    end
    end_of_packet <= 1'b1;
    @(posedge hclk);
    end_of_packet <= 1'b0;
  endtask
endmodule

// ### bench/rxs_top_tb_top.sv
module rxs_top_tb_top
  import rxs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [31:0] A_ST = 32'h0000_0020;
  localparam logic [31:0] A_CNT = 32'h0000_0024;
  localparam logic [31:0] A_IS = 32'h0000_0030;
  localparam logic [31:0] A_IM = 32'h0000_0034;
  localparam logic [31:0] ADDRS [5] = '{A_ST, A_CNT, A_IS, A_IM, 32'h0000_003C};
  logic        hclk, hresetn, hwrite, hreadyout, hresp, rx_go_restart, irq;
  logic [31:0] haddr, hwdata, hrdata, dummy;
  logic [1:0]  htrans, rx_data_mode;
  logic [7:0]  length_field, rx_length;
  logic        start_of_packet, end_of_packet, length_load, length_invalid, payload_byte;
  logic        crc_done, crc_bad, crc_zero_seed, rx_is_ack, expect_ack, rx_code_64, rx_framed;
  int          num_errors, checks;

  rxs_top i_rxs_top (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .start_of_packet, .end_of_packet,
    .length_load, .length_field, .length_invalid, .rx_go_restart, .payload_byte, .crc_done,
    .crc_bad, .crc_zero_seed, .rx_is_ack, .expect_ack, .rx_code_64, .rx_data_mode,
    .rx_framed, .rx_length, .irq
  );
  rxs_tx_model i_rxs_tx_model (
    .hclk, .start_of_packet, .end_of_packet, .length_load, .length_field, .length_invalid,
    .payload_byte, .crc_done, .crc_bad, .crc_zero_seed, .rx_is_ack, .expect_ack,
    .rx_code_64, .rx_data_mode, .rx_framed
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // no fixed latency assumed: both phases wait on hready
  task automatic xfer(input bit w, input logic [31:0] a, v, output logic [31:0] d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic rdchk(input string what, input logic [31:0] a, exp);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0000_0000, d);
    chk(what, exp, d);
  endtask

  // early status read races the packet so the checker sees fresh results
  task automatic pkt(input logic [7:0] len, q, input bit cut, bl, input logic [7:0] est, ecnt);
    logic [31:0] d;
    fork
      i_rxs_tx_model.send(len, q, cut, bl);
      if (!cut) begin
        @(posedge crc_done);
        @(posedge hclk);
        xfer(1'b0, A_ST, 32'h0000_0000, d);
      end
    join
    rdchk("status", A_ST, {24'h0000_00, est});
    rdchk("count", A_CNT, {24'h0000_00, ecnt});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    foreach (ADDRS[i]) begin
      rdchk("reset value", ADDRS[i], 32'h0000_0000);
      if (i < 2 || i == 4) begin
        xfer(1'b1, ADDRS[i], 32'h0000_00FF, dummy);
        rdchk("read only", ADDRS[i], 32'h0000_0000);
      end
    end
  endtask

  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      pkt(8'(m), {5'b00100, m[0], m[1:0]}, 1'b0, 1'b0, {5'b00000, m[0], m[1:0]}, 8'(m));
    end
  endtask

  task automatic t_errs();
    pkt(8'h02, 8'b1011_1011, 1'b0, 1'b0, 8'hDA, 8'h02);
    pkt(8'h01, 8'b1100_0101, 1'b0, 1'b0, 8'h86, 8'h01);
  endtask

  task automatic t_eop();
    pkt(8'h04, 8'h20, 1'b1, 1'b0, 8'hA6, 8'h00);
    pkt(8'h01, 8'h20, 1'b0, 1'b0, 8'h00, 8'h01);
    pkt(8'h05, 8'h20, 1'b0, 1'b1, 8'h20, 8'h05);
    chk("length", 32'h0000_0000, {24'h0000_00, rx_length});
    rx_go_restart <= 1'b1;
    @(posedge hclk);
    rx_go_restart <= 1'b0;
    rdchk("count", A_CNT, 32'h0000_0000);
  endtask

  task automatic t_irq();
    xfer(1'b1, A_IS, 32'h0000_000F, dummy);
    xfer(1'b1, A_IM, 32'h0000_0002, dummy);
    pkt(8'h01, 8'h20, 1'b0, 1'b0, 8'h00, 8'h01);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    pkt(8'h01, 8'h28, 1'b0, 1'b0, 8'h08, 8'h01);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rdchk("irq status", A_IS, 32'h0000_0003);
    xfer(1'b1, A_IS, 32'h0000_0002, dummy);
    repeat (2) @(posedge hclk);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rdchk("irq status", A_IS, 32'h0000_0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hwrite, rx_go_restart} = 3'b000;
    htrans = 2'b00;
    {haddr, hwdata} = 64'h0;
    {num_errors, checks} = 64'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_modes();
    t_errs();
    t_eop();
    t_irq();
    complete_run();
  end

  // generous span: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge hclk);
    num_errors++;
    complete_run();
  end
endmodule
